// *** hdl/msap_pkg.sv ***
package msap_pkg;

  // clock and timing
  localparam int unsigned CLK_PERIOD_NS = 50;
  localparam int unsigned CONV_TIME_NS = 1000;
  localparam int unsigned CAL_TIME_NS = 100000;
  // least times round up to whole cycles
  localparam int unsigned CONV_CYCLES = (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CAL_CYCLES = (CAL_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // widths
  localparam int unsigned CNT_W = 12;
  localparam int unsigned DATA_W = 16;
  localparam int unsigned CHAN_W = 6;
  localparam int unsigned MUX_W = 5;
  localparam int unsigned ALM_W = 16;
  localparam int unsigned NSENS = 11;
  localparam int unsigned NCORE = 7;
  localparam int unsigned NCHAN = 64;

  localparam logic [CNT_W-1:0] CONV_LAST = CNT_W'(CONV_CYCLES - 1);
  localparam logic [CNT_W-1:0] CAL_LAST = CNT_W'(CAL_CYCLES - 1);

  // alarm vector layout
  localparam int unsigned ALM_OR_CORE_BIT = 7;
  localparam int unsigned ALM_USER_LO_BIT = 8;
  localparam int unsigned ALM_OR_ALL_BIT = 15;

  // sensor index to converter channel: temp, core, aux, bram, three ps, four user
  localparam logic [CHAN_W-1:0] SENS_CHAN [NSENS] = '{
    6'h00, 6'h01, 6'h02, 6'h06, 6'h0D, 6'h0E, 6'h0F, 6'h20, 6'h21, 6'h22, 6'h23};
  localparam int unsigned SENS_TEMP = 0;

  // values after reset
  localparam logic [DATA_W-1:0] RESULT_RST = 16'h0000;
  localparam logic [ALM_W-1:0] ALM_RST = 16'h0000;

  typedef enum logic [1:0] {ST_IDLE, ST_CONV, ST_CAL} msap_state_t;

endpackage

// *** hdl/msap_res_if.sv ***
`timescale 1ns/1ps
`default_nettype none
// one conversion result, valid for a single cycle
interface msap_res_if;
  logic vld;
  logic [5:0] chan;
  logic [15:0] data;
  modport src (output vld, output chan, output data);
  modport dst (input vld, input chan, input data);
endinterface
`default_nettype wire

// *** hdl/msap_stat_mem.sv ***
`timescale 1ns/1ps
`default_nettype none
// per-channel result store, written on each completed conversion
module msap_stat_mem (
  input wire logic clk_i,
  input wire logic rst_b_i,
  msap_res_if.dst wr,
  input wire logic [msap_pkg::CHAN_W-1:0] rd_addr_i,
  output logic [msap_pkg::DATA_W-1:0] rd_data_o
);
  import msap_pkg::*;

  typedef struct packed {
    logic [DATA_W-1:0] rd;
  } msap_mem_st_t;

  msap_mem_st_t st_ff;
  msap_mem_st_t nxt_st;
  logic [DATA_W-1:0] mem [NCHAN];

  // storage has no reset; unread channels are undefined until converted
  always_ff @(posedge clk_i) begin
    if (wr.vld) begin
      mem[wr.chan] <= wr.data;
    end
  end

  // registered read port
  always_comb begin
    nxt_st = st_ff;
    nxt_st.rd = mem[rd_addr_i];
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      st_ff <= '{rd: RESULT_RST};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign rd_data_o = st_ff.rd;

endmodule // msap_stat_mem
`default_nettype wire

// *** hdl/msap_alarm.sv ***
`timescale 1ns/1ps
`default_nettype none
// threshold compare per sensor and alarm summary
module msap_alarm (
  input wire logic clk_i,
  input wire logic rst_b_i,
  msap_res_if.dst res,
  input wire logic [msap_pkg::NSENS*msap_pkg::DATA_W-1:0] upper_thresh_i,
  input wire logic [msap_pkg::NSENS*msap_pkg::DATA_W-1:0] lower_thresh_i,
  input wire logic [msap_pkg::NSENS-1:0] alarm_en_i,
  input wire logic [msap_pkg::DATA_W-1:0] ot_limit_i,
  output logic [msap_pkg::ALM_W-1:0] alarm_vector_o,
  output logic overtemp_flag_o
);
  import msap_pkg::*;

  typedef struct packed {
    logic [ALM_W-1:0] vec;
    logic ot;
  } msap_alm_st_t;

  msap_alm_st_t st_ff;
  msap_alm_st_t nxt_st;
  logic [NSENS-1:0] cur_alm;
  logic [NSENS-1:0] new_alm;

  assign cur_alm = {st_ff.vec[ALM_USER_LO_BIT+3:ALM_USER_LO_BIT], st_ff.vec[NCORE-1:0]};

  // a sensor's bit follows its latest result; disabling clears it at once
  for (genvar s = 0; s < NSENS; s++) begin : g_sens
    logic hit;
    logic viol;
    assign hit = res.vld && (res.chan == SENS_CHAN[s]);
    assign viol = (res.data > upper_thresh_i[s*DATA_W +: DATA_W]) ||
                  (res.data < lower_thresh_i[s*DATA_W +: DATA_W]);
    assign new_alm[s] = alarm_en_i[s] & (hit ? viol : cur_alm[s]);
  end

  // summaries are built from the next bits so they never lag a cycle
  always_comb begin
    nxt_st = st_ff;
    nxt_st.vec = ALM_RST;
    nxt_st.vec[NCORE-1:0] = new_alm[NCORE-1:0];
    nxt_st.vec[ALM_OR_CORE_BIT] = |new_alm[NCORE-1:0];
    nxt_st.vec[ALM_USER_LO_BIT+3:ALM_USER_LO_BIT] = new_alm[NSENS-1:NCORE];
    nxt_st.vec[ALM_OR_ALL_BIT] = |new_alm;
    if (res.vld && (res.chan == SENS_CHAN[SENS_TEMP])) begin
      nxt_st.ot = res.data > ot_limit_i;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      st_ff <= '{vec: ALM_RST, ot: 1'b0};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign alarm_vector_o = st_ff.vec;
  assign overtemp_flag_o = st_ff.ot;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);

  AST_ALM_OR_CORE: assert property (
    alarm_vector_o[7] == (|alarm_vector_o[6:0]))
    else $error("core alarm summary wrong");
  AST_ALM_OR_ALL: assert property (
    alarm_vector_o[15] == ((|alarm_vector_o[11:8]) | (|alarm_vector_o[6:0])))
    else $error("full alarm summary wrong");
  AST_ALM_TEMP_SET: assert property (
    res.vld && res.chan == 6'h00 && alarm_en_i[0] && res.data > upper_thresh_i[15:0]
    |=> alarm_vector_o[0] && alarm_vector_o[7] && alarm_vector_o[15])
    else $error("temperature alarm not raised");
  AST_ALM_USER0_CLR: assert property (
    res.vld && res.chan == 6'h20 && res.data <= upper_thresh_i[127:112] &&
    res.data >= lower_thresh_i[127:112] |=> !alarm_vector_o[8])
    else $error("user0 alarm not cleared");

endmodule // msap_alarm
`default_nettype wire

// *** hdl/msap_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module msap_top (
  input wire logic mclk_i,
  input wire logic rst_b_i,
  input wire logic event_mode_i,
  input wire logic ext_mux_mode_i,
  input wire logic seq_mode_i,
  input wire logic [msap_pkg::CHAN_W-1:0] single_chan_i,
  input wire logic [msap_pkg::CHAN_W-1:0] seq_last_i,
  input wire logic conversion_trigger_i,
  input wire logic trigger_clock_input_i,
  input wire logic cal_req_i,
  input wire logic [msap_pkg::DATA_W-1:0] adc_data_i,
  input wire logic [msap_pkg::NSENS*msap_pkg::DATA_W-1:0] upper_thresh_i,
  input wire logic [msap_pkg::NSENS*msap_pkg::DATA_W-1:0] lower_thresh_i,
  input wire logic [msap_pkg::NSENS-1:0] alarm_en_i,
  input wire logic [msap_pkg::DATA_W-1:0] ot_limit_i,
  input wire logic [msap_pkg::CHAN_W-1:0] stat_rd_addr_i,
  output logic [msap_pkg::DATA_W-1:0] stat_rd_data_o,
  output logic [msap_pkg::ALM_W-1:0] alarm_vector_o,
  output logic overtemp_flag_o,
  output logic [msap_pkg::MUX_W-1:0] ext_mux_select_o,
  output logic [msap_pkg::CHAN_W-1:0] channel_o,
  output logic conversion_done_o,
  output logic sequence_done_o,
  output logic busy_o,
  input wire logic scan_lock_req_i,
  input wire logic scan_write_tgl_i,
  input wire logic scan_txn_active_i,
  input wire logic scan_write_clr_i,
  output logic scan_port_lock_o,
  output logic scan_write_flag_o,
  output logic scan_transfer_active_o,
  input wire logic serial_data_pin_i,
  input wire logic serial_data_drive_req_i,
  output logic serial_data_level_o,
  output logic serial_data_drive_ctl_o,
  input wire logic serial_clock_pin_i,
  input wire logic serial_clock_drive_req_i,
  output logic serial_clock_level_o,
  output logic serial_clock_drive_ctl_o,
  input wire logic alert_en_i,
  output logic alert_drive_ctl_o
);
  import msap_pkg::*;

  localparam int CONV_DLY = CONV_CYCLES;

  typedef struct packed {
    msap_state_t st;
    logic [CNT_W-1:0] cnt;
    logic cal_pend;
    logic [CHAN_W-1:0] idx;
    logic [CHAN_W-1:0] cur;
    logic [CHAN_W-1:0] chan;
    logic [MUX_W-1:0] mux;
    logic [DATA_W-1:0] res;
    logic done;
    logic seq_done;
    logic busy;
    logic trg_d;
    logic [2:0] tck_sh;
    logic [1:0] lock_sh;
    logic [2:0] wtg_sh;
    logic [2:0] wtg_rdy;
    logic [1:0] act_sh;
    logic wflag;
    logic [1:0] sda_sh;
    logic [1:0] scl_sh;
    logic sda_drv;
    logic scl_drv;
    logic alert;
  } msap_top_st_t;

  msap_top_st_t st_ff;
  msap_top_st_t nxt_st;
  logic [1:0] rst_sh_ff;
  logic rst_b;
  logic trg_edge;
  logic scan_wr_evt;
  logic [CHAN_W-1:0] idx_succ;
  logic [ALM_W-1:0] alm_vec;

  msap_res_if res_bus ();

  // asynchronous assert, release after two port-clock edges; with the clock
  // stopped the release simply waits for the first edges that arrive
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rst_sh_ff <= 2'h0;
    end else begin
      rst_sh_ff <= {rst_sh_ff[0], 1'b1};
    end
  end
  assign rst_b = rst_sh_ff[1];

  // either trigger source; the clock-net one only after its synchroniser
  assign trg_edge = (conversion_trigger_i & ~st_ff.trg_d) |
                    (st_ff.tck_sh[1] & ~st_ff.tck_sh[2]);
  // a toggle level left over from before reset is no write; a toggle in the
  // first cycles after release is lost, traded for no false flag
  assign scan_wr_evt = (st_ff.wtg_sh[1] ^ st_ff.wtg_sh[2]) & st_ff.wtg_rdy[2];
  assign idx_succ = (st_ff.idx >= seq_last_i) ? '0 : st_ff.idx + 1'b1;

  // sequencer, synchronisers and flag logic
  always_comb begin
    nxt_st = st_ff;
    nxt_st.done = 1'b0;
    nxt_st.seq_done = 1'b0;
    nxt_st.trg_d = conversion_trigger_i;
    nxt_st.tck_sh = {st_ff.tck_sh[1:0], trigger_clock_input_i};
    nxt_st.lock_sh = {st_ff.lock_sh[0], scan_lock_req_i};
    nxt_st.wtg_sh = {st_ff.wtg_sh[1:0], scan_write_tgl_i};
    nxt_st.wtg_rdy = {st_ff.wtg_rdy[1:0], 1'b1};
    nxt_st.act_sh = {st_ff.act_sh[0], scan_txn_active_i};
    nxt_st.sda_sh = {st_ff.sda_sh[0], serial_data_pin_i};
    nxt_st.scl_sh = {st_ff.scl_sh[0], serial_clock_pin_i};
    // a calibration asked for mid-conversion waits for the idle slot
    if (cal_req_i) begin
      nxt_st.cal_pend = 1'b1;
    end
    case (st_ff.st)
      ST_IDLE: begin
        if (st_ff.cal_pend || cal_req_i) begin
          nxt_st.st = ST_CAL;
          nxt_st.cnt = CAL_LAST;
          nxt_st.cal_pend = 1'b0;
        end else if (!event_mode_i || trg_edge) begin
          nxt_st.st = ST_CONV;
          nxt_st.cnt = CONV_LAST;
          nxt_st.cur = seq_mode_i ? st_ff.idx : single_chan_i;
          if (seq_mode_i) begin
            nxt_st.idx = idx_succ;
          end
        end
      end
      ST_CONV: begin
        // triggers are only looked at in idle, so one mid-conversion is lost
        if (st_ff.cnt == '0) begin
          nxt_st.st = ST_IDLE;
          nxt_st.res = adc_data_i;
          nxt_st.chan = st_ff.cur;
          nxt_st.done = 1'b1;
          nxt_st.seq_done = seq_mode_i && (st_ff.cur >= seq_last_i);
        end else begin
          nxt_st.cnt = st_ff.cnt - 1'b1;
        end
      end
      ST_CAL: begin
        if (st_ff.cnt == '0) begin
          nxt_st.st = ST_IDLE;
        end else begin
          nxt_st.cnt = st_ff.cnt - 1'b1;
        end
      end
      default: begin
        nxt_st.st = ST_IDLE;
      end
    endcase
    // address of the channel the converter will take up next
    if (ext_mux_mode_i) begin
      nxt_st.mux = seq_mode_i ? nxt_st.idx[MUX_W-1:0] : single_chan_i[MUX_W-1:0];
    end else begin
      nxt_st.mux = '0;
    end
    nxt_st.busy = nxt_st.st != ST_IDLE;
    // set wins over a clear in the same cycle
    if (scan_write_clr_i) begin
      nxt_st.wflag = 1'b0;
    end
    if (scan_wr_evt) begin
      nxt_st.wflag = 1'b1;
    end
    nxt_st.sda_drv = serial_data_drive_req_i;
    nxt_st.scl_drv = serial_clock_drive_req_i;
    nxt_st.alert = alert_en_i & alm_vec[ALM_OR_ALL_BIT];
  end

  // every output is a flop on the port clock
  always_ff @(posedge mclk_i or negedge rst_b) begin
    if (!rst_b) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign res_bus.vld = st_ff.done;
  assign res_bus.chan = st_ff.chan;
  assign res_bus.data = st_ff.res;

  msap_stat_mem u_mem (
    .clk_i(mclk_i),
    .rst_b_i(rst_b),
    .wr(res_bus.dst),
    .rd_addr_i(stat_rd_addr_i),
    .rd_data_o(stat_rd_data_o)
  );

  msap_alarm u_alarm (
    .clk_i(mclk_i),
    .rst_b_i(rst_b),
    .res(res_bus.dst),
    .upper_thresh_i(upper_thresh_i),
    .lower_thresh_i(lower_thresh_i),
    .alarm_en_i(alarm_en_i),
    .ot_limit_i(ot_limit_i),
    .alarm_vector_o(alm_vec),
    .overtemp_flag_o(overtemp_flag_o)
  );

  // port map; lock low tells fabric the register port is free
  assign alarm_vector_o = alm_vec;
  assign ext_mux_select_o = st_ff.mux;
  assign channel_o = st_ff.chan;
  assign conversion_done_o = st_ff.done;
  assign sequence_done_o = st_ff.seq_done;
  assign busy_o = st_ff.busy;
  assign scan_port_lock_o = st_ff.lock_sh[1];
  assign scan_write_flag_o = st_ff.wflag;
  assign scan_transfer_active_o = st_ff.act_sh[1];
  assign serial_data_level_o = st_ff.sda_sh[1];
  assign serial_data_drive_ctl_o = st_ff.sda_drv;
  assign serial_clock_level_o = st_ff.scl_sh[1];
  assign serial_clock_drive_ctl_o = st_ff.scl_drv;
  assign alert_drive_ctl_o = st_ff.alert;

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_b);

  AST_DONE_ONE_CYCLE: assert property (
    conversion_done_o |=> !conversion_done_o)
    else $error("conversion done wider than one cycle");
  AST_SEQ_WITH_DONE: assert property (
    sequence_done_o |-> conversion_done_o && channel_o >= seq_last_i)
    else $error("sequence done without last conversion");
  AST_CONV_LENGTH: assert property (
    $rose(st_ff.st == ST_CONV) |-> busy_o ##CONV_DLY conversion_done_o)
    else $error("conversion length or busy wrong");
  AST_BUSY_BEFORE_DONE: assert property (
    conversion_done_o |-> $past(busy_o) && !busy_o || st_ff.st == ST_CONV)
    else $error("done without a preceding busy conversion");
  AST_EVT_HOLD: assert property (
    event_mode_i && st_ff.st == ST_IDLE && !trg_edge && !cal_req_i && !st_ff.cal_pend
    |=> !busy_o)
    else $error("conversion started without trigger in event mode");
  AST_EVT_START: assert property (
    event_mode_i && st_ff.st == ST_IDLE && st_ff.tck_sh[1] && !st_ff.tck_sh[2] &&
    !cal_req_i && !st_ff.cal_pend |=> st_ff.st == ST_CONV && busy_o)
    else $error("clock trigger did not start a conversion");
  AST_CHAN_AT_DONE: assert property (
    conversion_done_o |-> channel_o == $past(st_ff.cur))
    else $error("channel output not the converted channel");
  AST_LOCK_FOLLOW: assert property (
    (scan_lock_req_i && rst_b) [*3] |-> scan_port_lock_o)
    else $error("lock flag not following request");
  AST_ACT_FOLLOW: assert property (
    !scan_txn_active_i [*3] |-> !scan_transfer_active_o)
    else $error("transfer active flag stuck");
  AST_WFLAG_SET: assert property (
    scan_wr_evt |=> scan_write_flag_o)
    else $error("scan write not flagged");
  AST_SDA_LEVEL: assert property (
    $past(rst_b, 2) |-> serial_data_level_o == $past(serial_data_pin_i, 2))
    else $error("serial data level path wrong");
  AST_MUX_OFF: assert property (
    !ext_mux_mode_i |=> ext_mux_select_o == 5'h00)
    else $error("mux address driven outside external mux mode");

  // pad, flag, strobe, sequencer and mux paths
  AST_SCL_LEVEL: assert property (
    $past(rst_b, 2) |-> serial_clock_level_o == $past(serial_clock_pin_i, 2))
    else $error("serial clock level path wrong");
  AST_SDA_DRIVE: assert property (
    $past(rst_b) |-> serial_data_drive_ctl_o == $past(serial_data_drive_req_i))
    else $error("serial data drive control wrong");
  AST_SCL_DRIVE: assert property (
    $past(rst_b) |-> serial_clock_drive_ctl_o == $past(serial_clock_drive_req_i))
    else $error("serial clock drive control wrong");
  AST_ALERT_CTL: assert property (
    $past(rst_b) |-> alert_drive_ctl_o == ($past(alert_en_i) && $past(alarm_vector_o[15])))
    else $error("alert drive control wrong");
  AST_ACT_SET: assert property (
    (scan_txn_active_i && rst_b) [*3] |-> scan_transfer_active_o)
    else $error("transfer active flag not raised");
  AST_LOCK_CLR: assert property (
    !scan_lock_req_i [*3] |-> !scan_port_lock_o)
    else $error("lock flag stuck high");
  AST_WFLAG_HOLD: assert property (
    scan_write_flag_o && !scan_write_clr_i |=> scan_write_flag_o)
    else $error("scan write flag lost without a clear");
  AST_WFLAG_CLR: assert property (
    scan_write_clr_i && !scan_wr_evt |=> !scan_write_flag_o)
    else $error("scan write flag not cleared");
  AST_CAL_BUSY: assert property (
    $rose(st_ff.st == ST_CAL) |-> busy_o [*8])
    else $error("busy low during calibration");
  AST_CAL_FIRST: assert property (
    st_ff.st == ST_IDLE && cal_req_i |=> st_ff.st == ST_CAL && busy_o)
    else $error("calibration request not taken from idle");
  AST_CONT_RUN: assert property (
    !event_mode_i && st_ff.st == ST_IDLE |=> busy_o)
    else $error("continuous mode did not start a conversion");
  AST_SEQ_ONLY_IN_SEQ: assert property (
    sequence_done_o |-> $past(seq_mode_i))
    else $error("sequence done outside sequence mode");
  AST_SEQ_ONE_CYCLE: assert property (
    sequence_done_o |=> !sequence_done_o)
    else $error("sequence done wider than one cycle");
  AST_MUX_SINGLE: assert property (
    ext_mux_mode_i && !seq_mode_i |=> ext_mux_select_o == $past(single_chan_i[MUX_W-1:0]))
    else $error("mux address not the selected channel");
  AST_CHAN_SYNC: assert property (
    $changed(channel_o) |-> conversion_done_o)
    else $error("channel output changed outside a done strobe");
  AST_OT_UPDATE: assert property (
    res_bus.vld && res_bus.chan == SENS_CHAN[SENS_TEMP]
    |=> overtemp_flag_o == ($past(res_bus.data) > $past(ot_limit_i)))
    else $error("overtemperature flag wrong");

endmodule // msap_top
`default_nettype wire

// *** dv/msap_fabric_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// fabric side: one-cycle triggers, port accesses only while unlocked
module msap_fabric_model (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic fire_i,
  input wire logic lock_i,
  output logic trig_o,
  output logic acc_o
);
  // a single-cycle pulse so the design sees exactly one rising edge
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      trig_o <= 1'b0;
      acc_o <= 1'b0;
    end else begin
      trig_o <= fire_i;
      acc_o <= fire_i & ~lock_i;
    end
  end
endmodule // msap_fabric_model
`default_nettype wire

// *** dv/monitor_status_alarm_ports_test.sv ***
`timescale 1ns/1ps
`default_nettype none
module monitor_status_alarm_ports_test;
  import msap_pkg::*;
  logic mclk_i, rst_b_i, event_mode_i, ext_mux_mode_i, seq_mode_i, conversion_trigger_i;
  logic trigger_clock_input_i, cal_req_i, overtemp_flag_o, conversion_done_o, sequence_done_o;
  logic busy_o, scan_lock_req_i, scan_write_tgl_i, scan_txn_active_i, scan_write_clr_i;
  logic scan_port_lock_o, scan_write_flag_o, scan_transfer_active_o, serial_data_pin_i;
  logic serial_data_drive_req_i, serial_data_level_o, serial_data_drive_ctl_o;
  logic serial_clock_pin_i, serial_clock_drive_req_i, serial_clock_level_o;
  logic serial_clock_drive_ctl_o, alert_en_i, alert_drive_ctl_o, fire, w_m;
  logic [5:0] single_chan_i, seq_last_i, stat_rd_addr_i, channel_o, prev_ch;
  logic [15:0] adc_data_i, ot_limit_i, stat_rd_data_o, alarm_vector_o, d;
  logic [175:0] upper_thresh_i, lower_thresh_i;
  logic [10:0] alarm_en_i, a_m;
  logic [4:0] ext_mux_select_o, mux_q, mux_prev;
  logic [15:0] up [11];
  logic [15:0] lo [11];
  logic [31:0] r;
  int seed = 32'hDFB73AEC;
  int error_cnt = 0;
  int check_count = 0;
  int cnt, s;

  msap_top i_msap_top (.mclk_i, .rst_b_i, .event_mode_i, .ext_mux_mode_i, .seq_mode_i,
    .single_chan_i, .seq_last_i, .conversion_trigger_i, .trigger_clock_input_i, .cal_req_i,
    .adc_data_i, .upper_thresh_i, .lower_thresh_i, .alarm_en_i, .ot_limit_i, .stat_rd_addr_i,
    .stat_rd_data_o, .alarm_vector_o, .overtemp_flag_o, .ext_mux_select_o, .channel_o,
    .conversion_done_o, .sequence_done_o, .busy_o, .scan_lock_req_i, .scan_write_tgl_i,
    .scan_txn_active_i, .scan_write_clr_i, .scan_port_lock_o, .scan_write_flag_o,
    .scan_transfer_active_o, .serial_data_pin_i, .serial_data_drive_req_i,
    .serial_data_level_o, .serial_data_drive_ctl_o, .serial_clock_pin_i,
    .serial_clock_drive_req_i, .serial_clock_level_o, .serial_clock_drive_ctl_o,
    .alert_en_i, .alert_drive_ctl_o);

  msap_fabric_model i_msap_fabric_model (.clk_i(mclk_i), .rst_b_i(rst_b_i), .fire_i(fire),
    .lock_i(scan_port_lock_o), .trig_o(conversion_trigger_i), .acc_o());

  // 20 MHz port clock
  initial begin
    mclk_i = 1'b0;
    forever #25 mclk_i = ~mclk_i;
  end

  // expected alarm vector from per-sensor violation state
  function automatic logic [15:0] alm_exp(input logic [10:0] a);
    alm_exp = 16'h0000;
    alm_exp[6:0] = a[6:0];
    alm_exp[7] = |a[6:0];
    alm_exp[11:8] = a[10:7];
    alm_exp[15] = |a;
  endfunction

  task automatic summarize;
    if (error_cnt == 0 && check_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // inputs always change a fixed 2 ns after the rising edge
  task automatic tick(input int n);
    repeat (n) @(posedge mclk_i);
    #2;
  endtask

  // bounded wait on busy, counting the cycles spent
  task automatic wait_busy(input logic want);
    cnt = 0;
    while (busy_o !== want) begin
      tick(1);
      cnt++;
      if (cnt > 3000) begin
        error_cnt++;
        summarize();
      end
    end
  endtask

  // k: 0 fabric trigger, 1 clock-net trigger, 2 calibration
  task automatic conv(input int k, input int len);
    fire = (k == 0);
    trigger_clock_input_i = (k == 1);
    cal_req_i = (k == 2);
    tick(1);
    fire = 1'b0;
    cal_req_i = 1'b0;
    wait_busy(1'b1);
    mux_q = ext_mux_select_o;
    fire = (k == 0); // a retrigger while busy has to be ignored
    tick(1);
    fire = 1'b0;
    wait_busy(1'b0);
    trigger_clock_input_i = 1'b0;
    chk(16'(cnt + 1), 16'(len));
    chk(16'(conversion_done_o), 16'(k != 2));
  endtask

  initial begin
    rst_b_i = 1'b0;
    {event_mode_i, ext_mux_mode_i, alarm_en_i} = {2'b11, 11'h7FF};
    {seq_mode_i, fire, trigger_clock_input_i, cal_req_i} = 4'h0;
    {scan_lock_req_i, scan_write_tgl_i, scan_txn_active_i, scan_write_clr_i} = 4'h0;
    {serial_data_pin_i, serial_data_drive_req_i, serial_clock_pin_i} = 3'h7;
    {serial_clock_drive_req_i, alert_en_i, w_m, a_m} = 14'h0000;
    {single_chan_i, seq_last_i, stat_rd_addr_i} = {6'h00, 6'h02, 6'h00};
    {adc_data_i, ot_limit_i} = {16'h0000, 16'h8000};
    // thresholds drawn once and held, lower never above upper
    for (int i = 0; i < 11; i++) begin
      up[i] = 16'($random(seed));
      lo[i] = 16'($random(seed));
      if (lo[i] > up[i]) {lo[i], up[i]} = {up[i], lo[i]};
      upper_thresh_i[16*i +: 16] = up[i];
      lower_thresh_i[16*i +: 16] = lo[i];
    end
    tick(1);
    chk(alarm_vector_o, 16'h0000);
    tick(11);
    rst_b_i = 1'b1;
    tick(30);
    chk(16'(busy_o), 16'h0000);
    conv(0, CONV_CYCLES);
    tick(10);
    chk(16'(busy_o), 16'h0000);
    // every sensor twice: random data, then threshold boundaries
    for (int i = 0; i < 22; i++) begin
      s = i % 11;
      single_chan_i = SENS_CHAN[s];
      stat_rd_addr_i = SENS_CHAN[s];
      d = (i < 11) ? 16'($random(seed)) : (i[0] ? up[s] : lo[s] - 16'h0001);
      adc_data_i = d;
      a_m[s] = (d > up[s]) || (d < lo[s]);
      conv(i % 2, CONV_CYCLES);
      chk(16'(channel_o), 16'(SENS_CHAN[s]));
      tick(1);
      chk(16'(conversion_done_o), 16'h0000);
      chk(alarm_vector_o, alm_exp(a_m));
      if (s == 0) begin
        chk(16'(overtemp_flag_o), 16'(d > ot_limit_i));
      end
      tick(1);
      chk(stat_rd_data_o, d);
    end
    // automatic sequence over channels 0..2
    seq_mode_i = 1'b1;
    for (int j = 0; j < 7; j++) begin
      conv(0, CONV_CYCLES);
      chk(16'(sequence_done_o), 16'(channel_o == seq_last_i));
      if (j > 0) begin
        chk(16'(channel_o[4:0]), 16'(mux_prev));
        chk(16'(channel_o), (prev_ch == seq_last_i) ? 16'h0000 : 16'(prev_ch + 1));
      end
      {mux_prev, prev_ch} = {mux_q, channel_o};
      // sequence channels 0..2 are sensors 0..2, so their alarms move too
      a_m[channel_o] = (d > up[channel_o]) || (d < lo[channel_o]);
      tick(1);
      chk(16'({conversion_done_o, sequence_done_o}), 16'h0000);
      chk(alarm_vector_o, alm_exp(a_m));
    end
    conv(2, CAL_CYCLES);
    // next sequence channel after the last one converted
    mux_prev = 5'((prev_ch == seq_last_i) ? 6'h00 : prev_ch + 6'h01);
    // scan flags, serial pads and alert control
    for (int j = 0; j < 12; j++) begin
      r = $random(seed);
      {serial_data_drive_req_i, scan_txn_active_i, scan_lock_req_i} = r[2:0];
      {serial_clock_pin_i, serial_clock_drive_req_i, serial_data_pin_i} = r[5:3];
      alert_en_i = r[6];
      ext_mux_mode_i = r[9];
      scan_write_tgl_i = scan_write_tgl_i ^ r[7];
      w_m = w_m | r[7];
      tick(4);
      chk(16'(scan_port_lock_o), 16'(r[0]));
      chk(16'(scan_transfer_active_o), 16'(r[1]));
      chk(16'({serial_data_level_o, serial_data_drive_ctl_o}), 16'(r[3:2]));
      chk(16'({serial_clock_level_o, serial_clock_drive_ctl_o}), 16'(r[5:4]));
      chk(16'(alert_drive_ctl_o), 16'(r[6]) & (alm_exp(a_m) >> 15));
      chk(16'(scan_write_flag_o), 16'(w_m));
      chk(16'(ext_mux_select_o), r[9] ? 16'(mux_prev) : 16'h0000);
      if (r[8]) begin
        scan_write_clr_i = 1'b1;
        tick(1);
        scan_write_clr_i = 1'b0;
        w_m = 1'b0;
        tick(1);
        chk(16'(scan_write_flag_o), 16'h0000);
      end
    end
    // reset in mid-conversion acts at once, then the block starts afresh
    seq_mode_i = 1'b0;
    fire = 1'b1;
    tick(1);
    fire = 1'b0;
    wait_busy(1'b1);
    rst_b_i = 1'b0;
    #1;
    chk(16'(busy_o), 16'h0000);
    chk(alarm_vector_o, 16'h0000);
    tick(2);
    rst_b_i = 1'b1;
    tick(3);
    chk(16'(busy_o), 16'h0000);
    conv(0, CONV_CYCLES);
    // free-running mode: conversions follow each other with one idle cycle
    event_mode_i = 1'b0;
    wait_busy(1'b1);
    wait_busy(1'b0);
    chk(16'(conversion_done_o), 16'h0001);
    tick(1);
    chk(16'(busy_o), 16'h0001);
    summarize();
  end
endmodule // monitor_status_alarm_ports_test
`default_nettype wire
